/* File: common/tpf_pkg.sv */
// tpf_pkg: shared constants and types of the transmit phase fifo clocking
// assumes: both link ends and the bench import this package whole
package tpf_pkg;

  // ----------------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------------
  localparam int TPF_NUM_BLK     = 2;
  localparam int TPF_CH_PER_BLK  = 4;
  localparam int TPF_DATA_W      = 16;
  localparam int TPF_CTRL_W      = 2;
  localparam int TPF_FIFO_DEPTH  = 8;
  localparam int TPF_FILL_START  = TPF_FIFO_DEPTH / 2;
  localparam int TPF_MASTER_BLK  = 0;
  localparam int TPF_AUTO_REF_CH = 0;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int TPF_CLK_NS     = 10;
  localparam int TPF_PAR_CLK_NS = 40;
  localparam int TPF_PAR_DIV    = TPF_PAR_CLK_NS / TPF_CLK_NS;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    TPF_MODE_NB = 3'h1,
    TPF_MODE_X4 = 3'h2,
    TPF_MODE_X8 = 3'h4
  } tpf_mode_t;

  typedef enum logic [2:0] {
    TPF_SRC_TXCLK = 3'h1,
    TPF_SRC_CORE  = 3'h2,
    TPF_SRC_PIN   = 3'h4
  } tpf_src_t;

  typedef enum logic [1:0] {
    TPF_ST_FILL = 2'h1,
    TPF_ST_RUN  = 2'h2
  } tpf_fifo_st_t;

endpackage

/* File: common/tpf_tx_if.sv */
// tpf_tx_if: fabric to transmitter link of all channels
// assumes: one clock; every clock of the link is a one-cycle enable
`timescale 1ns/1ps
interface tpf_tx_if
  import tpf_pkg::*;
#(
  parameter int NUM_BLK    = TPF_NUM_BLK,
  parameter int CH_PER_BLK = TPF_CH_PER_BLK,
  parameter int DATA_W     = TPF_DATA_W,
  parameter int CTRL_W     = TPF_CTRL_W
);
  localparam int NCH = NUM_BLK * CH_PER_BLK;

  logic [NCH-1:0]              wr_tick;
  logic [NUM_BLK-1:0]          core_tick;
  logic [NCH-1:0]              user_wr_tick;
  logic [NCH-1:0][DATA_W-1:0]  tx_data;
  logic [NCH-1:0][CTRL_W-1:0]  tx_ctrl;

  modport dev (
    output wr_tick,
    output core_tick,
    input  user_wr_tick,
    input  tx_data,
    input  tx_ctrl
  );

  modport fab (
    input  wr_tick,
    input  core_tick,
    output user_wr_tick,
    output tx_data,
    output tx_ctrl
  );
endinterface

/* File: rtl/tpf_tx_dev.sv */
// tpf_tx_dev: transmit phase fifo of every channel and its clocking
// assumes: fabric end keeps its data on the clock it is handed
// Function
// - fifo absorbs phase only, equal frequencies
// - bonded modes write from bonded core clock
// - bonded fabric logic runs on core clock
// - identical channels of a block share one parallel clock
// - each block uses its channel 0 clock
// - user write clock replaces automatic selection
// - shared user clock has zero offset
// - same shared clock drives fabric data logic
// - frequency mismatch gives overflow or underrun
// - non-bonded reads local divider, halved with serializer
// - x4 reads block first unit divider
// - x8 reads master block first unit divider
// - user clock only from allowed sources
`timescale 1ns/1ps
module tpf_tx_dev
  import tpf_pkg::*;
#(
  parameter int NUM_BLK    = TPF_NUM_BLK,
  parameter int CH_PER_BLK = TPF_CH_PER_BLK,
  parameter int DATA_W     = TPF_DATA_W,
  parameter int CTRL_W     = TPF_CTRL_W,
  parameter int FIFO_DEPTH = TPF_FIFO_DEPTH,
  parameter int PAR_DIV    = TPF_PAR_DIV
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          nrst,
  // link
  tpf_tx_if.dev                              lnk,
  // configuration
  input  tpf_mode_t                          mode,
  input  wire logic                          byte_ser,
  input  wire logic [NUM_BLK*CH_PER_BLK-1:0] user_clk_en,
  input  wire logic [NUM_BLK*CH_PER_BLK-1:0] ident,
  // serializer side
  output logic [NUM_BLK*CH_PER_BLK-1:0][DATA_W-1:0] ser_data,
  output logic [NUM_BLK*CH_PER_BLK-1:0][CTRL_W-1:0] ser_ctrl,
  output logic [NUM_BLK*CH_PER_BLK-1:0]             ser_valid,
  // status
  output logic [NUM_BLK*CH_PER_BLK-1:0]             running,
  output logic [NUM_BLK*CH_PER_BLK-1:0]             overflow,
  output logic [NUM_BLK*CH_PER_BLK-1:0]             underrun
);
  localparam int NCH  = NUM_BLK * CH_PER_BLK;
  localparam int WW   = DATA_W + CTRL_W;
  localparam int AW   = $clog2(FIFO_DEPTH);
  localparam int DIVW = $clog2(PAR_DIV);

  localparam logic [AW:0]     FULL_CNT  = (AW+1)'(FIFO_DEPTH);
  localparam logic [AW:0]     START_CNT = (AW+1)'(TPF_FILL_START);
  localparam logic [DIVW-1:0] DIV_LAST  = DIVW'(PAR_DIV - 1);

  // ----------------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------------
  if (PAR_DIV < 2) begin : g_chk_div
    $error("tpf_tx_dev: PAR_DIV must be at least 2");
  end
  if (FIFO_DEPTH < 4 || (1 << AW) != FIFO_DEPTH) begin : g_chk_depth
    $error("tpf_tx_dev: FIFO_DEPTH must be a power of two, 4 or more");
  end
  if (TPF_MASTER_BLK >= NUM_BLK || TPF_AUTO_REF_CH >= CH_PER_BLK)
  begin : g_chk_ref
    $error("tpf_tx_dev: reference block or channel out of range");
  end

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [NCH-1:0][DIVW-1:0]           lcnt;
    logic [NCH-1:0]                     lhalf;
    logic [NUM_BLK-1:0][DIVW-1:0]       bcnt;
    logic [NUM_BLK-1:0]                 bhalf;
    logic [NCH-1:0][FIFO_DEPTH-1:0][WW-1:0] mem;
    logic [NCH-1:0][AW-1:0]             wp;
    logic [NCH-1:0][AW-1:0]             rp;
    logic [NCH-1:0][AW:0]               cnt;
    tpf_fifo_st_t [NCH-1:0]             fst;
    logic [NCH-1:0][WW-1:0]             dout;
    logic [NCH-1:0]                     vld;
    logic [NCH-1:0]                     ovf;
    logic [NCH-1:0]                     unf;
  } tpf_dev_st_t;

  tpf_dev_st_t st;
  tpf_dev_st_t next_st;

  logic [NCH-1:0]     loc_rd;
  logic [NUM_BLK-1:0] core_rd;
  logic [NCH-1:0]     rd_tick;
  logic [NCH-1:0]     auto_wr;
  logic [NCH-1:0]     wr_tick;

  // ----------------------------------------------------------------------
  // parallel clock dividers
  // ----------------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      // local divider, halved when the byte serializer is used
      loc_rd[c] = (st.lcnt[c] == '0) & (~byte_ser | st.lhalf[c]);
    end
    for (int b = 0; b < NUM_BLK; b++) begin
      // first clock unit divider of each block
      core_rd[b] = (st.bcnt[b] == '0) & (~byte_ser | st.bhalf[b]);
    end
  end

  // ----------------------------------------------------------------------
  // read and write clock selection
  // ----------------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      case (mode)
        TPF_MODE_NB: begin
          rd_tick[c] = loc_rd[c];
          // identical channels follow channel 0 of their own block
          auto_wr[c] = ident[c]
                       ? loc_rd[(c / CH_PER_BLK) * CH_PER_BLK
                                + TPF_AUTO_REF_CH]
                       : loc_rd[c];
        end
        TPF_MODE_X4: begin
          rd_tick[c] = core_rd[c / CH_PER_BLK];
          auto_wr[c] = core_rd[c / CH_PER_BLK];
        end
        TPF_MODE_X8: begin
          rd_tick[c] = core_rd[TPF_MASTER_BLK];
          auto_wr[c] = core_rd[TPF_MASTER_BLK];
        end
        default: begin
          rd_tick[c] = 1'b0;
          auto_wr[c] = 1'b0;
        end
      endcase
      // user write clock overrides the automatic choice
      wr_tick[c] = user_clk_en[c] ? lnk.user_wr_tick[c]
                                  : auto_wr[c];
    end
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic do_rd;
    logic do_wr;
    logic [AW:0] c_next;
    do_rd   = 1'b0;
    do_wr   = 1'b0;
    c_next  = '0;
    next_st = st;
    for (int c = 0; c < NCH; c++) begin
      next_st.lcnt[c] = (st.lcnt[c] == DIV_LAST) ? '0
                                                 : st.lcnt[c] + 1'b1;
      if (st.lcnt[c] == '0) begin
        next_st.lhalf[c] = ~st.lhalf[c];
      end
    end
    for (int b = 0; b < NUM_BLK; b++) begin
      next_st.bcnt[b] = (st.bcnt[b] == DIV_LAST) ? '0
                                                 : st.bcnt[b] + 1'b1;
      if (st.bcnt[b] == '0) begin
        next_st.bhalf[b] = ~st.bhalf[b];
      end
    end
    for (int c = 0; c < NCH; c++) begin
      next_st.vld[c] = 1'b0;
      c_next = st.cnt[c];
      // reads start only after half the fifo has filled
      do_rd = rd_tick[c] & (st.fst[c] == TPF_ST_RUN);
      if (do_rd) begin
        if (st.cnt[c] == '0) begin
          next_st.unf[c] = 1'b1;
        end else begin
          next_st.dout[c] = st.mem[c][st.rp[c]];
          next_st.vld[c]  = 1'b1;
          next_st.rp[c]   = st.rp[c] + 1'b1;
          c_next          = c_next - 1'b1;
        end
      end
      do_wr = wr_tick[c];
      if (do_wr) begin
        if (st.cnt[c] == FULL_CNT && !(do_rd && st.cnt[c] != '0)) begin
          next_st.ovf[c] = 1'b1;
        end else begin
          next_st.mem[c][st.wp[c]] = {lnk.tx_ctrl[c], lnk.tx_data[c]};
          next_st.wp[c]            = st.wp[c] + 1'b1;
          c_next                   = c_next + 1'b1;
        end
      end
      next_st.cnt[c] = c_next;
      case (st.fst[c])
        TPF_ST_FILL: begin
          if (st.cnt[c] >= START_CNT) begin
            next_st.fst[c] = TPF_ST_RUN;
          end
        end
        TPF_ST_RUN: begin
          next_st.fst[c] = TPF_ST_RUN;
        end
        default: begin
          next_st.fst[c] = TPF_ST_FILL;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      for (int c = 0; c < NCH; c++) begin
        st.fst[c] <= TPF_ST_FILL;
      end
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      ser_data[c] = st.dout[c][DATA_W-1:0];
      ser_ctrl[c] = st.dout[c][WW-1:DATA_W];
      running[c]  = (st.fst[c] == TPF_ST_RUN);
    end
  end

  // forwarded clocks carry the read rate, so zero offset by design
  assign lnk.wr_tick   = auto_wr;
  assign lnk.core_tick = core_rd;
  assign ser_valid     = st.vld;
  assign overflow      = st.ovf;
  assign underrun      = st.unf;

endmodule

/* File: rtl/tpf_tx_fab.sv */
// tpf_tx_fab: fabric transmit data and control logic of all channels
// assumes: device end forwards the auto write clock of each channel
`timescale 1ns/1ps
module tpf_tx_fab
  import tpf_pkg::*;
#(
  parameter int NUM_BLK    = TPF_NUM_BLK,
  parameter int CH_PER_BLK = TPF_CH_PER_BLK,
  parameter int DATA_W     = TPF_DATA_W,
  parameter int CTRL_W     = TPF_CTRL_W
) (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         nrst,
  // link
  tpf_tx_if.fab                             lnk,
  // clock choice
  input  wire logic                         use_user_clk,
  input  tpf_src_t                          user_src,
  input  wire logic                         ext_clk_pin,
  // user data
  input  wire logic [NUM_BLK*CH_PER_BLK-1:0][DATA_W-1:0] user_data,
  input  wire logic [NUM_BLK*CH_PER_BLK-1:0][CTRL_W-1:0] user_ctrl,
  output logic      [NUM_BLK*CH_PER_BLK-1:0]             user_take
);
  localparam int NCH = NUM_BLK * CH_PER_BLK;

  if (TPF_MASTER_BLK >= NUM_BLK) begin : g_chk
    $error("tpf_tx_fab: master block outside the link");
  end

  typedef struct packed {
    logic                       pin_s1;
    logic                       pin_s2;
    logic                       pin_s3;
    logic [NCH-1:0][DATA_W-1:0] data;
    logic [NCH-1:0][CTRL_W-1:0] ctrl;
  } tpf_fab_st_t;

  tpf_fab_st_t st;
  tpf_fab_st_t next_st;
  logic        shared_tick;
  logic [NCH-1:0] ch_tick;

  // ----------------------------------------------------------------------
  // clock selection
  // ----------------------------------------------------------------------
  always_comb begin
    // only allowed sources are selectable; nothing gated or self made
    case (user_src)
      TPF_SRC_TXCLK: shared_tick = lnk.wr_tick[0];
      TPF_SRC_CORE:  shared_tick = lnk.core_tick[TPF_MASTER_BLK];
      TPF_SRC_PIN:   shared_tick = st.pin_s2 & ~st.pin_s3;
      default:       shared_tick = 1'b0;
    endcase
    for (int c = 0; c < NCH; c++) begin
      // user clock feeds every connected input, zero offset assumed
      lnk.user_wr_tick[c] = use_user_clk & shared_tick;
      // data logic runs on the very same clock
      ch_tick[c] = use_user_clk ? shared_tick
                                : lnk.wr_tick[c];
    end
  end

  // ----------------------------------------------------------------------
  // data registers
  // ----------------------------------------------------------------------
  always_comb begin
    next_st        = st;
    next_st.pin_s1 = ext_clk_pin;
    next_st.pin_s2 = st.pin_s1;
    next_st.pin_s3 = st.pin_s2;
    for (int c = 0; c < NCH; c++) begin
      if (ch_tick[c]) begin
        next_st.data[c] = user_data[c];
        next_st.ctrl[c] = user_ctrl[c];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign user_take   = ch_tick;
  assign lnk.tx_data = st.data;
  assign lnk.tx_ctrl = st.ctrl;

endmodule

/* File: tb/tb_tx_phase_fifo_write_clocking.sv */
// tb_tx_phase_fifo_write_clocking: both link ends back to back
// assumes: package defaults, 100 MHz clock
`timescale 1ns/1ps
module tb_tx_phase_fifo_write_clocking import tpf_pkg::*;;
  logic             clk;
  logic             nrst;
  logic             byte_ser;
  logic             use_user_clk;
  logic             ext_clk_pin;
  logic             pin_on;
  logic             chk_on;
  tpf_mode_t        mode;
  tpf_src_t         user_src;
  logic [7:0]       user_clk_en;
  logic [7:0]       ident;
  logic [7:0]       user_take;
  logic [7:0]       ser_valid;
  logic [7:0]       running;
  logic [7:0]       overflow;
  logic [7:0]       underrun;
  logic [7:0]       seen;
  logic [7:0][15:0] user_data;
  logic [7:0][15:0] ser_data;
  logic [7:0][1:0]  user_ctrl;
  logic [7:0][1:0]  ser_ctrl;
  logic [17:0]      q [8][$];
  int               err_count;
  int               comparisons;
  int               pin_half = 16;

  tpf_tx_if lnk ();
  tpf_tx_dev tpf_tx_dev_i (.clk(clk), .nrst(nrst), .lnk(lnk), .mode(mode),
    .byte_ser(byte_ser), .user_clk_en(user_clk_en), .ident(ident),
    .ser_data(ser_data), .ser_ctrl(ser_ctrl), .ser_valid(ser_valid),
    .running(running), .overflow(overflow), .underrun(underrun));
  tpf_tx_fab tpf_tx_fab_i (.clk(clk), .nrst(nrst), .lnk(lnk),
    .use_user_clk(use_user_clk), .user_src(user_src),
    .ext_clk_pin(ext_clk_pin), .user_data(user_data),
    .user_ctrl(user_ctrl), .user_take(user_take));
  tpf_tx_monitor mon (.clk(clk), .nrst(nrst), .wr_tick(lnk.wr_tick),
    .core_tick(lnk.core_tick), .user_wr_tick(lnk.user_wr_tick),
    .tx_data(lnk.tx_data), .mode(mode), .byte_ser(byte_ser),
    .ident(ident));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // mismatched pin clock, period twice pin_half
  always #(pin_half) ext_clk_pin <= pin_on ? ~ext_clk_pin : 1'b0;

  task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
    comparisons++;
    if (seen_v !== exp_v) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen_v,
               exp_v);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // fabric words offered and words read out, in order per channel
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    for (int c = 0; c < 8; c++) begin
      // fabric flops hold reset, so nothing is taken then
      if (user_take[c] && nrst) begin
        q[c].push_back({user_ctrl[c], user_data[c]});
        user_data[c] <= user_data[c] + 16'h0001;
        user_ctrl[c] <= user_data[c][1:0] + 2'h1;
      end
      if (ser_valid[c] && chk_on) begin
        if (!seen[c] && {ser_ctrl[c], ser_data[c]} === 18'h00000) begin
          seen[c] = 1'b1;
        end else begin
          seen[c] = 1'b1;
          check({14'h0, ser_ctrl[c], ser_data[c]},
                {14'h0, q[c].pop_front()});
        end
      end
    end
  end

  task automatic run(input tpf_mode_t m, input logic bs, input logic [7:0] idt,
                     input logic uen, input tpf_src_t s, input logic bad);
    logic [31:0] exp_flags;
    // reset first, so the old queues are dropped only once idle
    nrst <= 1'b0;
    chk_on <= 1'b0;
    @(posedge clk);
    mode <= m;
    byte_ser <= bs;
    ident <= idt;
    use_user_clk <= uen;
    user_clk_en <= {8{uen}};
    user_src <= s;
    pin_on <= (s == TPF_SRC_PIN);
    chk_on <= !bad;
    for (int c = 0; c < 8; c++) begin
      q[c].delete();
      user_data[c] <= {4'(c + 1), 12'h000};
      user_ctrl[c] <= 2'h0;
    end
    seen = 8'h00;
    repeat (9) @(posedge clk);
    nrst <= 1'b1;
    repeat (400) @(posedge clk);
    if (bad) begin
      // fast write clock overflows, slow one runs dry
      exp_flags = (pin_half < 20) ? 32'h0000FF00 : 32'h000000FF;
      check({16'h0, overflow, underrun}, exp_flags);
    end else begin
      check({16'h0, overflow, underrun}, 32'h0);
      check({24'h0, running}, 32'h000000FF);
    end
    $display("test done: mode %h byte_ser %b user %b", m, bs, uen);
  endtask

  initial begin
    err_count = 0;
    comparisons = 0;
    nrst = 1'b0;
    ext_clk_pin = 1'b0;
    pin_on = 1'b0;
    chk_on = 1'b0;
    mode = TPF_MODE_NB;
    user_src = TPF_SRC_TXCLK;
    byte_ser = 1'b0;
    use_user_clk = 1'b0;
    user_clk_en = 8'h00;
    ident = 8'h00;
    user_data = '0;
    user_ctrl = '0;
    seen = 8'h00;
    run(TPF_MODE_NB, 1'b0, 8'h00, 1'b0, TPF_SRC_TXCLK, 1'b0);
    run(TPF_MODE_NB, 1'b1, 8'hEE, 1'b0, TPF_SRC_TXCLK, 1'b0);
    run(TPF_MODE_X4, 1'b0, 8'h00, 1'b0, TPF_SRC_TXCLK, 1'b0);
    run(TPF_MODE_X4, 1'b1, 8'h00, 1'b0, TPF_SRC_TXCLK, 1'b0);
    run(TPF_MODE_X8, 1'b1, 8'h00, 1'b0, TPF_SRC_TXCLK, 1'b0);
    run(TPF_MODE_X4, 1'b0, 8'h00, 1'b1, TPF_SRC_CORE, 1'b0);
    run(TPF_MODE_NB, 1'b0, 8'h00, 1'b1, TPF_SRC_TXCLK, 1'b0);
    run(TPF_MODE_NB, 1'b0, 8'h00, 1'b1, TPF_SRC_PIN, 1'b1);
    pin_half = 24;
    run(TPF_MODE_NB, 1'b0, 8'h00, 1'b1, TPF_SRC_PIN, 1'b1);
    conclude();
  end

  // watchdog, tests need about 37 us
  initial begin
    #100000;
    err_count++;
    conclude();
  end
endmodule

/* File: tb/tpf_tx_monitor.sv */
// tpf_tx_monitor: concurrent checks on the fabric to transmitter link
// assumes: default geometry of two blocks of four channels
`timescale 1ns/1ps
module tpf_tx_monitor
  import tpf_pkg::*;
(
  // clock and reset
  input wire logic             clk,
  input wire logic             nrst,
  // link
  input wire logic [7:0]       wr_tick,
  input wire logic [1:0]       core_tick,
  input wire logic [7:0]       user_wr_tick,
  input wire logic [7:0][15:0] tx_data,
  // configuration
  input tpf_mode_t             mode,
  input wire logic             byte_ser,
  input wire logic [7:0]       ident
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------------------
  // clock selection
  // ----------------------------------------------------------------------
  chk_x4_core_write: assert property (
    mode == TPF_MODE_X4 |->
      wr_tick == {{4{core_tick[1]}}, {4{core_tick[0]}}})
    else $error("x4 write tick differs from block core tick");
  chk_x8_master_core: assert property (
    mode == TPF_MODE_X8 |-> wr_tick == {8{core_tick[0]}})
    else $error("x8 write tick differs from master core tick");
  chk_ident_shared: assert property (
    mode == TPF_MODE_NB |->
      ((wr_tick ^ {{4{wr_tick[4]}}, {4{wr_tick[0]}}}) & ident) == 8'h00)
    else $error("identical channel not on its block channel 0 tick");
  chk_user_common: assert property (
    user_wr_tick == 8'h00 || user_wr_tick == 8'hFF)
    else $error("user write ticks not common to all channels");

  // ----------------------------------------------------------------------
  // rates and data hold
  // ----------------------------------------------------------------------
  chk_tick_gap: assert property (
    wr_tick[0] |=> !wr_tick[0] [*3])
    else $error("write ticks closer than four cycles");
  chk_nb_period: assert property (
    mode == TPF_MODE_NB && wr_tick[0] && !byte_ser |-> ##4 wr_tick[0])
    else $error("parallel tick period not four cycles");
  chk_nb_half: assert property (
    mode == TPF_MODE_NB && wr_tick[0] && byte_ser |=> !wr_tick[0] [*7])
    else $error("halved parallel tick too early");
  chk_bond_half: assert property (
    mode != TPF_MODE_NB && core_tick[0] && byte_ser |-> ##8 core_tick[0])
    else $error("halved core tick period not eight cycles");
  chk_data_hold: assert property (
    $changed(tx_data[0]) |-> $past(wr_tick[0] | user_wr_tick[0]))
    else $error("fabric data changed without a tick");

  cov_x4: cover property (mode == TPF_MODE_X4 && core_tick[0]);
  cov_user: cover property (user_wr_tick[0]);
  cov_half: cover property (byte_ser && wr_tick[0]);
endmodule
